// ---- cpu_addr_regs.vh ----
// constants of the cpu addressing mode unit
// assumes: included by cpu_addressing_mode_unit.v and its checker
`ifndef CPU_ADDR_REGS_VH
`define CPU_ADDR_REGS_VH

// ****************************************
// addressing modes
// ****************************************
`define MODE_DIR       3'h0
`define MODE_EXT       3'h1
`define MODE_IX        3'h2
`define MODE_IX1       3'h3
`define MODE_IX2       3'h4
`define MODE_REL       3'h5
`define MODE_IMM       3'h6
`define MODE_INH       3'h7

// ****************************************
// instruction classes
// ****************************************
`define CLS_REG_MEM    3'h0
`define CLS_RMW        3'h1
`define CLS_JUMP       3'h2
`define CLS_BRANCH     3'h3
`define CLS_BIT_BRANCH 3'h4
`define CLS_BIT_MANIP  3'h5
`define CLS_CONTROL    3'h6

// ****************************************
// branch conditions
// ****************************************
`define COND_ALWAYS    4'h0
`define COND_NEVER     4'h1
`define COND_HIGHER    4'h2
`define COND_LOW_SAME  4'h3
`define COND_C_CLEAR   4'h4
`define COND_C_SET     4'h5
`define COND_Z_CLEAR   4'h6
`define COND_Z_SET     4'h7
`define COND_H_CLEAR   4'h8
`define COND_H_SET     4'h9
`define COND_N_CLEAR   4'hA
`define COND_N_SET     4'hB
`define COND_I_CLEAR   4'hC
`define COND_I_SET     4'hD
`define COND_IRQ_LOW   4'hE
`define COND_IRQ_HIGH  4'hF

// ****************************************
// read-modify-write operations
// ****************************************
`define RMW_INC        4'h0
`define RMW_DEC        4'h1
`define RMW_CLR        4'h2
`define RMW_COM        4'h3
`define RMW_NEG        4'h4
`define RMW_ROL        4'h5
`define RMW_ROR        4'h6
`define RMW_LOGIC_SHL  4'h7
`define RMW_LSR        4'h8
`define RMW_ASR        4'h9
`define RMW_TST        4'hA
`define RMW_ARITH_SHL  4'hB

// ****************************************
// lengths, widths and timing
// ****************************************
`define LEN_ONE        2'h1
`define LEN_TWO        2'h2
`define LEN_THREE      2'h3
`define ZERO_BYTE      8'h00
`define MUL_CYCLES     4'hB
`define MUL_STEPS      4'h8
`define CNT_ZERO       4'h0
`define CNT_ONE        4'h1

`endif

// ---- cpu_addressing_mode_unit.v ----
// operand address, instruction length, mode legality, branch target and multiply
// assumes: opcode bytes and cpu registers stable on START; one clock, sync reset
`timescale 1ns/100ps
`include "cpu_addr_regs.vh"

module cpu_addressing_mode_unit (
  // clock and reset
  input  wire        CLOCK,
  input  wire        RST,
  // decode request
  input  wire        START,
  input  wire [2:0]  MODE,
  input  wire [2:0]  OP_CLASS,
  input  wire [3:0]  COND,
  input  wire        BIT_SENSE,
  input  wire [3:0]  RMW_OP,
  input  wire [7:0]  OPERAND1,
  input  wire [7:0]  OPERAND2,
  // cpu state
  input  wire [7:0]  INDEX,
  input  wire [7:0]  ACCUM,
  input  wire [15:0] PC_BASE,
  input  wire        FLAG_C,
  input  wire        FLAG_Z,
  input  wire        FLAG_N,
  input  wire        FLAG_H,
  input  wire        FLAG_I,
  input  wire        IRQ_LEVEL,
  input  wire        TEST_BIT,
  // decode answer
  output reg         DONE,
  output reg  [15:0] EFF_ADDR,
  output reg  [1:0]  INSTR_LEN,
  output reg         MODE_OK,
  output reg  [15:0] NEXT_PC,
  output reg         TAKEN,
  output reg  [3:0]  RMW_CODE,
  // multiply
  input  wire        MUL_START,
  output reg         MUL_BUSY,
  output reg         MUL_DONE,
  output reg  [7:0]  MUL_HIGH,
  output reg  [7:0]  MUL_LOW
);

  // ****************************************
  // functions
  // ****************************************
  function mode_allowed;
    input [2:0] cls;
    input [2:0] mode;
    begin
      mode_allowed = 1'b0;
      case (cls)
        `CLS_REG_MEM:    mode_allowed = (mode != `MODE_REL) && (mode != `MODE_INH);
        `CLS_RMW:        mode_allowed = (mode == `MODE_DIR) || (mode == `MODE_IX) ||
                                        (mode == `MODE_IX1) || (mode == `MODE_INH);
        `CLS_JUMP:       mode_allowed = (mode == `MODE_DIR) || (mode == `MODE_EXT) ||
                                        (mode == `MODE_IX) || (mode == `MODE_IX1) ||
                                        (mode == `MODE_IX2);
        `CLS_BRANCH:     mode_allowed = (mode == `MODE_REL);
        `CLS_BIT_BRANCH: mode_allowed = (mode == `MODE_DIR) || (mode == `MODE_REL);
        `CLS_BIT_MANIP:  mode_allowed = (mode == `MODE_DIR);
        `CLS_CONTROL:    mode_allowed = (mode == `MODE_INH);
        default:         mode_allowed = 1'b0;
      endcase
    end
  endfunction

  function [1:0] length_of;
    input [2:0] cls;
    input [2:0] mode;
    begin
      length_of = `LEN_ONE;
      case (mode)
        `MODE_DIR: length_of = (cls == `CLS_BIT_BRANCH) ? `LEN_THREE : `LEN_TWO;
        `MODE_EXT: length_of = `LEN_THREE;
        `MODE_IX:  length_of = `LEN_ONE;
        `MODE_IX1: length_of = `LEN_TWO;
        `MODE_IX2: length_of = `LEN_THREE;
        `MODE_REL: length_of = (cls == `CLS_BIT_BRANCH) ? `LEN_THREE : `LEN_TWO;
        `MODE_IMM: length_of = `LEN_TWO;
        `MODE_INH: length_of = `LEN_ONE;
        default:   length_of = `LEN_ONE;
      endcase
    end
  endfunction

  function cond_true;
    input [3:0] cond;
    input       c;
    input       z;
    input       n;
    input       h;
    input       i;
    input       irq;
    begin
      cond_true = 1'b0;
      case (cond)
        `COND_ALWAYS:   cond_true = 1'b1;
        `COND_NEVER:    cond_true = 1'b0;
        `COND_HIGHER:   cond_true = ~(c | z);
        `COND_LOW_SAME: cond_true = c | z;
        `COND_C_CLEAR:  cond_true = ~c;
        `COND_C_SET:    cond_true = c;
        `COND_Z_CLEAR:  cond_true = ~z;
        `COND_Z_SET:    cond_true = z;
        `COND_H_CLEAR:  cond_true = ~h;
        `COND_H_SET:    cond_true = h;
        `COND_N_CLEAR:  cond_true = ~n;
        `COND_N_SET:    cond_true = n;
        `COND_I_CLEAR:  cond_true = ~i;
        `COND_I_SET:    cond_true = i;
        `COND_IRQ_LOW:  cond_true = ~irq;
        `COND_IRQ_HIGH: cond_true = irq;
        default:        cond_true = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // combinational decode
  // ****************************************
  reg [15:0] next_eff_addr;
  reg [15:0] next_pc;
  reg        next_taken;
  reg [3:0]  next_rmw_code;
  reg [7:0]  rel_offset;

  always @* begin
    rel_offset = (OP_CLASS == `CLS_BIT_BRANCH) ? OPERAND2 : OPERAND1;
    case (MODE)
      `MODE_DIR: next_eff_addr = {`ZERO_BYTE, OPERAND1};
      `MODE_EXT: next_eff_addr = {OPERAND1, OPERAND2};
      `MODE_IX:  next_eff_addr = {`ZERO_BYTE, INDEX};
      `MODE_IX1: next_eff_addr = {`ZERO_BYTE, OPERAND1} + {`ZERO_BYTE, INDEX};
      `MODE_IX2: next_eff_addr = {OPERAND1, OPERAND2} + {`ZERO_BYTE, INDEX};
      default:   next_eff_addr = {`ZERO_BYTE, OPERAND1};
    endcase
    if (OP_CLASS == `CLS_BIT_BRANCH)
      next_taken = (TEST_BIT == BIT_SENSE);
    else if (OP_CLASS == `CLS_BRANCH)
      next_taken = cond_true(COND, FLAG_C, FLAG_Z, FLAG_N, FLAG_H, FLAG_I, IRQ_LEVEL);
    else
      next_taken = 1'b0;
    // pc base is the location after the branch instruction
    if (next_taken)
      next_pc = PC_BASE + {{8{rel_offset[7]}}, rel_offset};
    else
      next_pc = PC_BASE;
    next_rmw_code = (RMW_OP == `RMW_ARITH_SHL) ? `RMW_LOGIC_SHL : RMW_OP;
  end

  // ****************************************
  // registered decode answer
  // ****************************************
  always @(posedge CLOCK) begin
    if (RST) begin
      DONE      <= 1'b0;
      EFF_ADDR  <= 16'h0000;
      INSTR_LEN <= 2'h0;
      MODE_OK   <= 1'b0;
      NEXT_PC   <= 16'h0000;
      TAKEN     <= 1'b0;
      RMW_CODE  <= 4'h0;
    end else begin
      DONE <= START;
      if (START) begin
        EFF_ADDR  <= next_eff_addr;
        INSTR_LEN <= length_of(OP_CLASS, MODE);
        MODE_OK   <= mode_allowed(OP_CLASS, MODE);
        NEXT_PC   <= next_pc;
        TAKEN     <= next_taken;
        RMW_CODE  <= next_rmw_code;
      end
    end
  end

  // ****************************************
  // multiply sequencer
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  reg [1:0]  state;
  reg [3:0]  count;
  reg [7:0]  multiplicand;
  reg [15:0] product;

  wire [8:0] partial = {1'b0, product[15:8]} + (product[0] ? {1'b0, multiplicand} : 9'h000);

  always @(posedge CLOCK) begin
    if (RST) begin
      state        <= ST_IDLE;
      count        <= `CNT_ZERO;
      multiplicand <= 8'h00;
      product      <= 16'h0000;
      MUL_BUSY     <= 1'b0;
      MUL_DONE     <= 1'b0;
      MUL_HIGH     <= 8'h00;
      MUL_LOW      <= 8'h00;
    end else begin
      MUL_DONE <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (MUL_START) begin
            multiplicand <= ACCUM;
            product      <= {`ZERO_BYTE, INDEX};
            count        <= `CNT_ONE;
            MUL_BUSY     <= 1'b1;
            state        <= ST_RUN;
          end
        end
        ST_RUN: begin
          // eight add-shift steps, then idle steps to fill the cycle budget
          if (count <= `MUL_STEPS)
            product <= {partial, product[7:1]};
          // registered on the last edge of the budget so done shows in the eleventh cycle
          if (count == (`MUL_CYCLES - `CNT_ONE)) begin
            MUL_HIGH <= product[15:8];
            MUL_LOW  <= product[7:0];
            MUL_DONE <= 1'b1;
            MUL_BUSY <= 1'b0;
            state    <= ST_IDLE;
          end else begin
            count <= count + `CNT_ONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ---- mem_bus_model.sv ----
// program memory seen by the decoder: the two bytes after the opcode
// assumes: the bench writes opcode bytes into mem before each request
`timescale 1ns/100ps

module mem_bus_model (
  // fetch pointer and operand bytes
  input  wire logic [7:0] ADDR,
  output logic      [7:0] BYTE1,
  output logic      [7:0] BYTE2
);
  logic [7:0] mem [0:255];
  // unwritten places read as a changing pattern, never as a stale value
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hA5 ^ 8'(i);
  end
  assign BYTE1 = mem[ADDR];
  assign BYTE2 = mem[ADDR + 8'h01];
endmodule

// ---- cpu_addr_checker.sv ----
// assertions on the ports of the addressing mode unit
// assumes: bound to cpu_addressing_mode_unit, one clock, sync reset
`timescale 1ns/100ps
`include "cpu_addr_regs.vh"

module cpu_addr_checker (
  input wire logic        CLOCK, RST, START, MUL_START, MUL_BUSY, MUL_DONE, TAKEN, MODE_OK,
  input wire logic        FLAG_C, FLAG_Z,
  input wire logic [2:0]  MODE, OP_CLASS,
  input wire logic [3:0]  COND, RMW_OP, RMW_CODE,
  input wire logic [7:0]  OPERAND1, OPERAND2, INDEX, ACCUM, MUL_HIGH, MUL_LOW,
  input wire logic [15:0] PC_BASE, EFF_ADDR, NEXT_PC,
  input wire logic [1:0]  INSTR_LEN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire rel_br = START && MODE == `MODE_REL && OP_CLASS == `CLS_BRANCH;

  dir_addr_a: assert property (START && MODE == `MODE_DIR |=>
    EFF_ADDR == {8'h00, $past(OPERAND1)}) else $error("direct address wrong");
  ext_addr_a: assert property (START && MODE == `MODE_EXT |=>
    EFF_ADDR == {$past(OPERAND1), $past(OPERAND2)} && INSTR_LEN == `LEN_THREE)
    else $error("extended wrong");
  ix_addr_a: assert property (START && MODE == `MODE_IX |=>
    EFF_ADDR == {8'h00, $past(INDEX)} && INSTR_LEN == `LEN_ONE) else $error("indexed wrong");
  ix1_addr_a: assert property (START && MODE == `MODE_IX1 |=>
    EFF_ADDR == {8'h00, $past(OPERAND1)} + {8'h00, $past(INDEX)}) else $error("ix1 wrong");
  ix2_addr_a: assert property (START && MODE == `MODE_IX2 |=>
    EFF_ADDR == {$past(OPERAND1), $past(OPERAND2)} + {8'h00, $past(INDEX)}) else $error("ix2 wrong");
  rel_target_a: assert property (rel_br && COND == `COND_ALWAYS |=> TAKEN &&
    NEXT_PC == $past(PC_BASE) + {{8{$past(OPERAND1[7])}}, $past(OPERAND1)}) else $error("target wrong");
  never_taken_a: assert property (rel_br && COND == `COND_NEVER |=>
    !TAKEN && NEXT_PC == $past(PC_BASE)) else $error("branch never moved");
  low_same_a: assert property (rel_br && COND == `COND_LOW_SAME |=>
    TAKEN == ($past(FLAG_C) | $past(FLAG_Z))) else $error("lower-or-same wrong");
  rel_class_a: assert property (START && MODE == `MODE_REL && OP_CLASS < `CLS_BRANCH
    |=> !MODE_OK) else $error("relative accepted");
  rmw_ix2_a: assert property (START && OP_CLASS == `CLS_RMW && MODE == `MODE_IX2
    |=> !MODE_OK) else $error("rmw ix2 accepted");
  shl_same_a: assert property (START && RMW_OP == `RMW_ARITH_SHL
    |=> RMW_CODE == `RMW_LOGIC_SHL) else $error("shift codes differ");
  mul_time_a: assert property (MUL_START && !MUL_BUSY |=> MUL_BUSY[*8] ##1 MUL_BUSY[*2]
    ##1 MUL_DONE && !MUL_BUSY) else $error("multiply timing wrong");
  mul_prod_a: assert property (MUL_START && !MUL_BUSY |-> ##11
    {MUL_HIGH, MUL_LOW} == $past(ACCUM, 11) * $past(INDEX, 11)) else $error("product wrong");

  cover property (START && MODE == `MODE_EXT);
  cover property (rel_br ##1 TAKEN);
  cover property (MUL_DONE);
endmodule

bind cpu_addressing_mode_unit cpu_addr_checker u_cpu_addr_checker (.*);

// ---- cpu_addressing_mode_unit_tb.sv ----
// self-checking bench for the addressing mode unit
// assumes: the checker is bound; operand bytes come from mem_bus_model
`timescale 1ns/100ps

module cpu_addressing_mode_unit_tb;
  logic        CLOCK = 0, RST = 1, START = 0, MUL_START = 0, TEST_BIT = 0, IRQ_LEVEL = 0;
  logic        FLAG_C = 0, FLAG_Z = 0, FLAG_N = 0, FLAG_H = 0, FLAG_I = 0, BIT_SENSE = 1;
  logic [2:0]  MODE = 0, OP_CLASS = 0;
  logic [3:0]  COND = 0, RMW_OP = 0, RMW_CODE;
  logic [7:0]  INDEX = 8'hFF, ACCUM = 8'hFF, OPERAND1, OPERAND2, MUL_HIGH, MUL_LOW;
  logic [15:0] PC_BASE = 16'h0100, EFF_ADDR, NEXT_PC;
  logic [1:0]  INSTR_LEN;
  logic        DONE, MODE_OK, TAKEN, MUL_BUSY, MUL_DONE;
  int          mismatches = 0, num_checks = 0, n;

  always #4 CLOCK = ~CLOCK;
  mem_bus_model u_mem_bus_model (.ADDR(8'h00), .BYTE1(OPERAND1), .BYTE2(OPERAND2));
  cpu_addressing_mode_unit u_cpu_addressing_mode_unit (.*);

  task chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // f = {rmw op, tested bit, irq pin, zero, carry}
  task dec(input logic [2:0] m, c, input logic [3:0] k, input logic [15:0] ops,
           input logic [7:0] f);
    u_mem_bus_model.mem[0] = ops[15:8];
    u_mem_bus_model.mem[1] = ops[7:0];
    @(posedge CLOCK);
    START <= 1;
    MODE <= m;
    OP_CLASS <= c;
    COND <= k;
    {RMW_OP, TEST_BIT, IRQ_LEVEL, FLAG_Z, FLAG_C} <= f;
    @(posedge CLOCK);
    START <= 0;
    #1 chk(DONE, 1);
  endtask
  task br(input logic [3:0] k, input logic [15:0] ops, input logic [7:0] f, input logic [15:0] pc,
          input logic t);
    dec(5, 3, k, ops, f);
    chk(NEXT_PC, pc);
    chk(TAKEN, t);
  endtask
  task ok(input logic [2:0] m, c, input logic e);
    dec(m, c, 0, 0, 0);
    chk(MODE_OK, e);
  endtask

  task t_modes;
    dec(0, 0, 0, 16'h3412, 0);
    chk(EFF_ADDR, 16'h0034);
    chk(INSTR_LEN, 2);
    dec(1, 0, 0, 16'h3412, 0);
    chk(EFF_ADDR, 16'h3412);
    chk(INSTR_LEN, 3);
    dec(2, 0, 0, 16'h3412, 0);
    chk(EFF_ADDR, 16'h00FF);
    chk(INSTR_LEN, 1);
    dec(3, 0, 0, 16'hFF00, 0);
    chk(EFF_ADDR, 16'h01FE);
    chk(INSTR_LEN, 2);
    dec(4, 0, 0, 16'hFFF0, 0);
    chk(EFF_ADDR, 16'h00EF);
    chk(INSTR_LEN, 3);
    dec(2, 1, 0, 0, 8'hB0);
    chk(RMW_CODE, 7);
    dec(2, 1, 0, 0, 8'h70);
    chk(RMW_CODE, 7);
  endtask
  task t_branch;
    br(0, 16'h8000, 0, 16'h0080, 1);
    br(0, 16'h7F00, 0, 16'h017F, 1);
    br(1, 16'h7F00, 0, 16'h0100, 0);
    br(3, 16'h1000, 8'h02, 16'h0110, 1);
    br(2, 16'h1000, 8'h02, 16'h0100, 0);
    br(2, 16'h1000, 8'h00, 16'h0110, 1);
    br(15, 16'h1000, 8'h04, 16'h0110, 1);
    br(14, 16'h1000, 8'h04, 16'h0100, 0);
    br(5, 16'h1000, 8'h01, 16'h0110, 1);
    br(4, 16'h1000, 8'h01, 16'h0100, 0);
    br(7, 16'h1000, 8'h02, 16'h0110, 1);
    br(6, 16'h1000, 8'h02, 16'h0100, 0);
    @(posedge CLOCK);
    {FLAG_N, FLAG_H, FLAG_I} <= 3'b101;
    br(11, 16'h1000, 0, 16'h0110, 1);
    br(10, 16'h1000, 0, 16'h0100, 0);
    br(8, 16'h1000, 0, 16'h0110, 1);
    br(9, 16'h1000, 0, 16'h0100, 0);
    br(13, 16'h1000, 0, 16'h0110, 1);
    br(12, 16'h1000, 0, 16'h0100, 0);
    dec(5, 4, 0, 16'h2005, 8'h08);
    chk(NEXT_PC, 16'h0105);
    chk(INSTR_LEN, 3);
    dec(5, 4, 0, 16'h2005, 8'h00);
    chk(NEXT_PC, 16'h0100);
    // bit-clear sense: branch when the tested bit is low
    @(posedge CLOCK);
    BIT_SENSE <= 0;
    dec(5, 4, 0, 16'h2005, 8'h00);
    chk(NEXT_PC, 16'h0105);
    chk(TAKEN, 1);
  endtask
  task t_legal;
    ok(5, 0, 0);
    ok(5, 2, 0);
    ok(5, 1, 0);
    ok(5, 4, 1);
    ok(5, 3, 1);
    ok(0, 5, 1);
    ok(0, 1, 1);
    ok(0, 4, 1);
    ok(1, 1, 0);
    ok(1, 5, 0);
    ok(1, 2, 1);
    ok(4, 1, 0);
    ok(3, 1, 1);
    ok(4, 2, 1);
    ok(4, 0, 1);
    ok(6, 0, 1);
  endtask
  // mid-run reset must clear results left by earlier scenarios
  task t_reset;
    @(posedge CLOCK);
    RST <= 1;
    @(posedge CLOCK);
    RST <= 0;
    #1 chk({MUL_HIGH, MUL_LOW}, 16'h0000);
    chk(MODE_OK, 0);
    chk(INSTR_LEN, 0);
  endtask
  task t_mul;
    @(posedge CLOCK);
    MUL_START <= 1;
    n = 0;
    // start held one extra cycle: the repeat while busy must be ignored
    do begin
      @(posedge CLOCK);
      n++;
      if (n == 2) MUL_START <= 0;
      #1;
    end while (MUL_DONE !== 1'b1 && n < 30);
    chk(n, 11);
    chk({MUL_HIGH, MUL_LOW}, 16'hFE01);
    @(posedge CLOCK);
    #1 chk(MUL_BUSY, 0);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge CLOCK);
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge CLOCK);
    RST <= 0;
    t_modes;
    t_branch;
    t_legal;
    t_mul;
    t_reset;
    complete_run;
  end
endmodule
